/* dv/mbmap_mem_model.sv */
// byte marker memory answering the mapper
`timescale 1ns/1ps
`default_nettype none
module mbmap_mem_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic mem_req,
    input wire mbmap_pkg::mbmap_mem_t mem_cmd,
    output logic [7:0] mem_rdata,
    output logic mem_ack
);
    logic [7:0] mem [int];
    int wait_r = 0;
    int pick = 0;
    initial
    begin
        mem_ack = 1'b0;
        mem_rdata = 8'h5a;
    end
    always @(posedge clk)
    begin
        int key;
        key = {mem_cmd.region, mem_cmd.addr};
        mem_ack <= 1'b0;
        // idle data keeps toggling so stale reads cannot match
        mem_rdata <= ~mem_rdata;
        if (!rst && mem_req && !mem_ack)
        begin
            if (wait_r == 0)
            begin
                mem_ack <= 1'b1;
                if (mem_cmd.we)
                    mem[key] = mem_cmd.wdata;
                mem_rdata <= mem.exists(key) ? mem[key] : 8'(key * 37 + 11);
                pick = pick + 1;
                wait_r <= pick % 4;
            end
            else
                wait_r <= wait_r - 1;
        end
    end
endmodule : mbmap_mem_model
`default_nettype wire

/* dv/mbmap_props.sv */
// concurrent checks on the mapper ports
`timescale 1ns/1ps
`default_nettype none
module mbmap_props #(
    parameter int BIT_SPAN = 10000
) (
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire logic REQ_VALID,
    input wire mbmap_pkg::mbmap_req_t REQ,
    input wire logic REQ_READY,
    input wire logic RSP_VALID,
    input wire logic RSP_ERR,
    input wire logic [15:0] RSP_DATA,
    input wire logic TX_VALID,
    input wire logic [7:0] TX_BYTE,
    input wire logic MEM_REQ,
    input wire mbmap_pkg::mbmap_mem_t MEM_CMD,
    input wire logic [7:0] MEM_RDATA,
    input wire logic MEM_ACK
);
    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (RST);
    logic take;
    logic first_r, first_nxt;
    mbmap_pkg::mbmap_req_t req_r, req_nxt;
    logic [7:0] hi_r, hi_nxt, lo_r, lo_nxt;
    logic [16:0] ack_r, ack_nxt;
    assign take = REQ_VALID && REQ_READY;
    always_comb
    begin
        first_nxt = take && !RST;
        req_nxt = take ? REQ : req_r;
        hi_nxt = (MEM_ACK && MEM_CMD.addr[0]) ? MEM_RDATA : hi_r;
        lo_nxt = (MEM_ACK && !MEM_CMD.addr[0]) ? MEM_RDATA : lo_r;
        ack_nxt = MEM_ACK ? MEM_CMD.addr : ack_r;
    end
    always_ff @(posedge CLK_SYS)
    begin
        first_r <= first_nxt;
        req_r <= req_nxt;
        hi_r <= hi_nxt;
        lo_r <= lo_nxt;
        ack_r <= ack_nxt;
    end
    sequence s_take_reg;
        take && REQ.kind[1];
    endsequence
    sequence s_tx_pair;
        TX_VALID && TX_BYTE == hi_r ##1 TX_VALID && TX_BYTE == lo_r;
    endsequence
    a_even_first:
        assert property (s_take_reg ##1 MEM_REQ |-> !MEM_CMD.addr[0])
        else $error("register access starts on odd byte");
    a_odd_next:
        assert property (MEM_ACK && req_r.kind[1] && !MEM_CMD.addr[0]
            |=> MEM_REQ && MEM_CMD.addr == ack_r + 17'h00001)
        else $error("neighbour byte not accessed");
    a_tx_order:
        assert property ($rose(TX_VALID) |-> s_tx_pair ##1 RSP_VALID)
        else $error("transmit order wrong");
    a_rsp_word:
        assert property (RSP_VALID && req_r.kind[1] && !req_r.write
            && !RSP_ERR |-> RSP_DATA == {hi_r, lo_r})
        else $error("register data not low byte first");
    a_coil_rmw:
        assert property (MEM_ACK && !MEM_CMD.we && req_r.kind == 2'h0
            && req_r.write |=> MEM_REQ && MEM_CMD.we && MEM_CMD.addr == ack_r)
        else $error("coil write not on read byte");
    a_vol_bits:
        assert property (first_r && req_r.kind == 2'h0
            && req_r.addr >= 40000 && req_r.addr < 40000 + BIT_SPAN
            |-> MEM_REQ && MEM_CMD.region == 3'h4
            && MEM_CMD.addr == (req_r.addr - 40000) / 8)
        else $error("internal bit mapped wrong");
    a_span_err:
        assert property (first_r && req_r.kind == 2'h0
            && req_r.addr >= 40000 + BIT_SPAN && req_r.addr <= 49999
            |-> RSP_VALID && RSP_ERR && !MEM_REQ)
        else $error("bit beyond span not refused");
    a_vol_reg:
        assert property (first_r && req_r.kind == 2'h2
            && req_r.addr >= 8000 && req_r.addr <= 27999
            |-> MEM_REQ && MEM_CMD.addr == (req_r.addr - 8000) * 2)
        else $error("volatile register mapped wrong");
    a_cmd_hold:
        assert property (MEM_REQ && !MEM_ACK |=> MEM_REQ && $stable(MEM_CMD))
        else $error("memory command moved before ack");
    a_ready_back:
        assert property (RSP_VALID |=> REQ_READY && !RSP_VALID)
        else $error("ready not back after response");
endmodule : mbmap_props
`default_nettype wire

/* dv/tb_modbus_marker_address_mapper.sv */
// self-checking bench for the marker address mapper
`timescale 1ns/1ps
`default_nettype none
module tb_modbus_marker_address_mapper;
    localparam int SPAN = 96;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic req_valid = 1'b0;
    mbmap_pkg::mbmap_req_t req = '0;
    logic req_ready, rsp_valid, rsp_err, tx_valid, mem_req, mem_ack;
    logic [15:0] rsp_data;
    logic [7:0] tx_byte, mem_rdata;
    mbmap_pkg::mbmap_mem_t mem_cmd;
    logic [7:0] ref_mem [int];
    logic [7:0] tx_q [$];
    int n_mismatch = 0;
    int n_checks = 0;
    int cycles = 0;
    int seed = 5518;
    always #10 clk = ~clk;
    mbmap_top #(.BIT_SPAN(SPAN)) DUT (.CLK_SYS(clk), .RST(rst),
        .REQ_VALID(req_valid), .REQ(req), .REQ_READY(req_ready),
        .RSP_VALID(rsp_valid), .RSP_ERR(rsp_err), .RSP_DATA(rsp_data),
        .TX_VALID(tx_valid), .TX_BYTE(tx_byte), .MEM_REQ(mem_req),
        .MEM_CMD(mem_cmd), .MEM_RDATA(mem_rdata), .MEM_ACK(mem_ack));
    mbmap_mem_model u_mem (.clk(clk), .rst(rst), .mem_req(mem_req),
        .mem_cmd(mem_cmd), .mem_rdata(mem_rdata), .mem_ack(mem_ack));
    task automatic wrap_up();
        if (n_mismatch == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : wrap_up
    task automatic chk_rsp(input logic [16:0] got, input logic [16:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("Error at %0t: response %h not %h", $time, got, exp);
        end
    endtask : chk_rsp
    task automatic chk_tx(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("Error at %0t: sent %h not %h", $time, got, exp);
        end
    endtask : chk_tx
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (tx_valid === 1'b1)
            tx_q.push_back(tx_byte);
        if (cycles == 20000)
        begin
            n_mismatch++;
            wrap_up();
        end
    end
    function automatic logic [7:0] rd(input int key);
        return ref_mem.exists(key) ? ref_mem[key] : 8'(key * 37 + 11);
    endfunction : rd
    // key is region * 131072 + byte marker, or -1 when refused
    function automatic int map(input int k, input int a);
        int r;
        r = 131072;
        if (k >= 2)
        begin
            if (a >= 3000 && a <= 4999)
                return (k == 3 ? 0 : r) + 3000 + 2 * (a - 3000);
            if (a >= 5000 && a <= 7999)
                return (k == 3 ? 2 * r : 3 * r) + 2 * (a - 5000);
            if (k == 2 && a >= 8000 && a <= 27999)
                return 4 * r + 2 * (a - 8000);
            if (k == 2 && a >= 28000 && a <= 47999)
                return 4 * r + 40000 + 2 * (a - 28000);
            return -1;
        end
        if (a <= 15999)
            return (k == 1 ? 0 : r) + 3000 + a / 8;
        if (a <= 23999)
            return (k == 1 ? 2 * r : 3 * r) + (a - 16000) / 8;
        if (a <= 39999)
            return (k == 1 ? 2 * r : 3 * r) + 2000 + (a - 24000) / 8;
        if (k == 0 && a >= 40000 && a < 40000 + SPAN)
            return 4 * r + (a - 40000) / 8;
        if (k == 0 && a >= 50000 && a < 50000 + SPAN)
            return 4 * r + 40000 + (a - 50000) / 8;
        return -1;
    endfunction : map
    task automatic op(input int k, input bit w, input int a, input int d);
        int key;
        int n;
        logic [7:0] b;
        logic [15:0] exp;
        key = (w && k[0]) ? -1 : map(k, a);
        b = rd(key);
        exp = 16'h0000;
        if (key >= 0 && !w)
            exp = k[1] ? {rd(key + 1), b} : {15'h0000, b[a % 8]};
        // a register write answers with the low byte that the memory acked
        if (key >= 0 && w && k[1])
            exp = {8'h00, 8'(d)};
        tx_q.delete();
        req_valid <= 1'b1;
        req <= {2'(k), w, 16'(a), 16'(d)};
        do
            @(posedge clk);
        while (req_ready !== 1'b1);
        req_valid <= 1'b0;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (rsp_valid !== 1'b1 && n < 60);
        chk_rsp({rsp_err, rsp_data}, {key < 0, exp});
        if (key >= 0 && k[1] && !w)
            chk_tx({tx_q.size() == 2 ? tx_q[0] : 8'hxx, tx_q[$]}, exp);
        if (key >= 0 && w && k[1])
        begin
            ref_mem[key] = 8'(d);
            ref_mem[key + 1] = 8'(d >> 8);
        end
        if (key >= 0 && w && !k[1])
        begin
            b[a % 8] = (d != 0);
            ref_mem[key] = b;
        end
    endtask : op
    initial
    begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        op(3, 0, 3001, 0);
        op(2, 1, 3015, 16'h1234);
        op(2, 0, 3015, 0);
        op(3, 0, 5000, 0);
        op(2, 1, 6000, 16'h00a5);
        op(1, 0, 24001, 0);
        op(2, 1, 8005, 16'hbeef);
        op(0, 0, 40095, 0);
        op(0, 0, 40096, 0);
        op(1, 0, 40000, 0);
        op(2, 1, 28002, 16'h5678);
        op(2, 1, 28003, 16'h1234);
        op(0, 0, 50035, 0);
        op(2, 1, 8000, 16'hc3a5);
        for (int i = 0; i < 16; i++)
            op(0, 0, 40000 + i, 0);
        op(0, 1, 40003, 16'hff00);
        op(2, 0, 8000, 0);
        op(3, 1, 3000, 1);
        op(2, 0, 2999, 0);
        op(3, 0, 48000, 0);
        for (int i = 0; i < 80; i++)
            op($random(seed) & 3, $random(seed) & 1, ($random(seed) & 1)
                ? 40000 + ($random(seed) & 127) : $random(seed) & 16'hffff,
                $random(seed) & 16'hffff);
        wrap_up();
    end
endmodule : tb_modbus_marker_address_mapper
bind mbmap_top mbmap_props #(.BIT_SPAN(BIT_SPAN)) u_props (
    .CLK_SYS(CLK_SYS), .RST(RST), .REQ_VALID(REQ_VALID), .REQ(REQ),
    .REQ_READY(REQ_READY), .RSP_VALID(RSP_VALID), .RSP_ERR(RSP_ERR),
    .RSP_DATA(RSP_DATA), .TX_VALID(TX_VALID), .TX_BYTE(TX_BYTE),
    .MEM_REQ(MEM_REQ), .MEM_CMD(MEM_CMD), .MEM_RDATA(MEM_RDATA),
    .MEM_ACK(MEM_ACK));
`default_nettype wire

/* verilog/mbmap_pkg.sv */
// shared types and constants of the marker address mapper
`default_nettype none
package mbmap_pkg;

    // register windows (16-bit register numbers)
    localparam logic [15:0] REG_SYS_LO = 16'h0bb8; // 3000
    localparam logic [15:0] REG_SYS_HI = 16'h1387; // 4999
    localparam logic [15:0] REG_IO_LO = 16'h1388; // 5000
    localparam logic [15:0] REG_NET_HI = 16'h1f3f; // 7999, io and network share
    localparam logic [15:0] REG_VOL_LO = 16'h1f40; // 8000
    localparam logic [15:0] REG_VOL_HI = 16'h6d5f; // 27999
    localparam logic [15:0] REG_RET_LO = 16'h6d60; // 28000
    localparam logic [15:0] REG_RET_HI = 16'hbb7f; // 47999

    // bit windows (coil / discrete numbers)
    localparam logic [15:0] BIT_SYS_HI = 16'h3e7f; // 15999
    localparam logic [15:0] BIT_IO_LO = 16'h3e80; // 16000
    localparam logic [15:0] BIT_IO_HI = 16'h5dbf; // 23999
    localparam logic [15:0] BIT_NET_LO = 16'h5dc0; // 24000
    localparam logic [15:0] BIT_NET_HI = 16'h9c3f; // 39999
    localparam logic [15:0] BIT_VOL_LO = 16'h9c40; // 40000
    localparam logic [15:0] BIT_VOL_HI = 16'hc34f; // 49999
    localparam logic [15:0] BIT_RET_LO = 16'hc350; // 50000
    localparam logic [15:0] BIT_RET_HI = 16'hea5f; // 59999
    localparam int BIT_SPAN_DEF = 10000; // bits per internal area

    // first byte marker number of the system, network and retentive areas
    localparam logic [16:0] BYTE_SYS_BASE = 17'h00bb8; // 3000
    localparam logic [16:0] BYTE_NET_BASE = 17'h007d0; // 2000
    localparam logic [16:0] BYTE_RET_BASE = 17'h09c40; // 40000

    localparam logic [15:0] RSP_ZERO = 16'h0000;

    typedef enum logic [2:0] {
        MBMAP_RG_STATUS = 3'h0,
        MBMAP_RG_COMMAND = 3'h1,
        MBMAP_RG_INPUT = 3'h2,
        MBMAP_RG_OUTPUT = 3'h3,
        MBMAP_RG_INTERNAL = 3'h4
    } mbmap_region_t;

    typedef enum logic [1:0] {
        MBMAP_K_COIL = 2'h0,
        MBMAP_K_DISC = 2'h1,
        MBMAP_K_HOLD = 2'h2,
        MBMAP_K_INREG = 2'h3
    } mbmap_kind_t;

    typedef enum logic [2:0] {
        MBMAP_S_IDLE = 3'h0,
        MBMAP_S_ACC_LO = 3'h1,
        MBMAP_S_ACC_HI = 3'h2,
        MBMAP_S_BIT_WR = 3'h3,
        MBMAP_S_TX_HI = 3'h4,
        MBMAP_S_TX_LO = 3'h5,
        MBMAP_S_RESP = 3'h6
    } mbmap_state_t;

    typedef struct packed {
        mbmap_kind_t kind;
        logic write;
        logic [15:0] addr;
        logic [15:0] wdata;
    } mbmap_req_t;

    typedef struct packed {
        logic we;
        mbmap_region_t region;
        logic [16:0] addr;
        logic [7:0] wdata;
    } mbmap_mem_t;

    typedef struct packed {
        logic ok;
        mbmap_region_t region;
        logic [16:0] byte_addr;
        logic [2:0] bitpos;
    } mbmap_map_t;

endpackage : mbmap_pkg
`default_nettype wire

/* verilog/mbmap_top.sv */
// modbus address to byte marker memory mapper
`timescale 1ns/1ps
`default_nettype none
module mbmap_top #(
    parameter int BIT_SPAN = mbmap_pkg::BIT_SPAN_DEF
) (
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire logic REQ_VALID,
    input wire mbmap_pkg::mbmap_req_t REQ,
    output logic REQ_READY,
    output logic RSP_VALID,
    output logic RSP_ERR,
    output logic [15:0] RSP_DATA,
    output logic TX_VALID,
    output logic [7:0] TX_BYTE,
    output logic MEM_REQ,
    output mbmap_pkg::mbmap_mem_t MEM_CMD,
    input wire logic [7:0] MEM_RDATA,
    input wire logic MEM_ACK
);

    if (BIT_SPAN < 1 || BIT_SPAN > mbmap_pkg::BIT_SPAN_DEF)
    begin : g_bad_span
        $error("BIT_SPAN must lie in 1..10000");
    end

    localparam logic [15:0] SPAN = 16'(BIT_SPAN);

    function automatic logic is_bit(input mbmap_pkg::mbmap_kind_t k);
        is_bit = (k == mbmap_pkg::MBMAP_K_COIL) ||
                 (k == mbmap_pkg::MBMAP_K_DISC);
    endfunction : is_bit

    function automatic logic is_rd_only(input mbmap_pkg::mbmap_kind_t k);
        is_rd_only = (k == mbmap_pkg::MBMAP_K_DISC) ||
                     (k == mbmap_pkg::MBMAP_K_INREG);
    endfunction : is_rd_only

    // pure address arithmetic, no memory knowledge
    function automatic mbmap_pkg::mbmap_map_t map_addr(
        input mbmap_pkg::mbmap_kind_t k,
        input logic [15:0] a
    );
        mbmap_pkg::mbmap_map_t m;
        logic [15:0] lo;
        logic [16:0] base;
        logic [15:0] off;
        logic ro;
        m = '0;
        lo = '0;
        base = '0;
        ro = is_rd_only(k);
        if (is_bit(k))
        begin
            if (a <= mbmap_pkg::BIT_SYS_HI)
            begin
                m.ok = 1'b1;
                base = mbmap_pkg::BYTE_SYS_BASE;
                m.region = ro ? mbmap_pkg::MBMAP_RG_STATUS
                              : mbmap_pkg::MBMAP_RG_COMMAND;
            end
            else if (a <= mbmap_pkg::BIT_IO_HI)
            begin
                m.ok = 1'b1;
                lo = mbmap_pkg::BIT_IO_LO;
                m.region = ro ? mbmap_pkg::MBMAP_RG_INPUT
                              : mbmap_pkg::MBMAP_RG_OUTPUT;
            end
            else if (a <= mbmap_pkg::BIT_NET_HI)
            begin
                m.ok = 1'b1;
                lo = mbmap_pkg::BIT_NET_LO;
                base = mbmap_pkg::BYTE_NET_BASE;
                m.region = ro ? mbmap_pkg::MBMAP_RG_INPUT
                              : mbmap_pkg::MBMAP_RG_OUTPUT;
            end
            else if (!ro && a <= mbmap_pkg::BIT_VOL_HI)
            begin
                m.ok = 1'b1;
                lo = mbmap_pkg::BIT_VOL_LO;
                m.region = mbmap_pkg::MBMAP_RG_INTERNAL;
            end
            else if (!ro && a <= mbmap_pkg::BIT_RET_HI)
            begin
                m.ok = 1'b1;
                lo = mbmap_pkg::BIT_RET_LO;
                base = mbmap_pkg::BYTE_RET_BASE;
                m.region = mbmap_pkg::MBMAP_RG_INTERNAL;
            end
            off = a - lo;
            // markers past the span are reachable by register only
            if (m.region == mbmap_pkg::MBMAP_RG_INTERNAL && off >= SPAN)
            begin
                m.ok = 1'b0;
            end
            m.byte_addr = base + 17'(off[15:3]);
            m.bitpos = off[2:0];
        end
        else
        begin
            if (a >= mbmap_pkg::REG_SYS_LO && a <= mbmap_pkg::REG_SYS_HI)
            begin
                m.ok = 1'b1;
                lo = mbmap_pkg::REG_SYS_LO;
                base = mbmap_pkg::BYTE_SYS_BASE;
                m.region = ro ? mbmap_pkg::MBMAP_RG_STATUS
                              : mbmap_pkg::MBMAP_RG_COMMAND;
            end
            else if (a >= mbmap_pkg::REG_IO_LO && a <= mbmap_pkg::REG_NET_HI)
            begin
                m.ok = 1'b1;
                lo = mbmap_pkg::REG_IO_LO;
                m.region = ro ? mbmap_pkg::MBMAP_RG_INPUT
                              : mbmap_pkg::MBMAP_RG_OUTPUT;
            end
            else if (!ro && a >= mbmap_pkg::REG_VOL_LO &&
                     a <= mbmap_pkg::REG_VOL_HI)
            begin
                m.ok = 1'b1;
                lo = mbmap_pkg::REG_VOL_LO;
                m.region = mbmap_pkg::MBMAP_RG_INTERNAL;
            end
            else if (!ro && a >= mbmap_pkg::REG_RET_LO &&
                     a <= mbmap_pkg::REG_RET_HI)
            begin
                m.ok = 1'b1;
                lo = mbmap_pkg::REG_RET_LO;
                base = mbmap_pkg::BYTE_RET_BASE;
                m.region = mbmap_pkg::MBMAP_RG_INTERNAL;
            end
            off = a - lo;
            // each register always starts on an even byte
            m.byte_addr = base + {off, 1'b0};
        end
        map_addr = m;
    endfunction : map_addr

    mbmap_pkg::mbmap_state_t state_r, state_nxt;
    mbmap_pkg::mbmap_req_t req_r, req_nxt;
    mbmap_pkg::mbmap_mem_t mem_r, mem_nxt;
    mbmap_pkg::mbmap_map_t map_now;
    logic [2:0] bitpos_r, bitpos_nxt;
    logic mem_req_r, mem_req_nxt;
    logic ready_r, ready_nxt;
    logic rsp_valid_r, rsp_valid_nxt;
    logic rsp_err_r, rsp_err_nxt;
    logic [15:0] rsp_data_r, rsp_data_nxt;
    logic tx_valid_r, tx_valid_nxt;
    logic [7:0] tx_byte_r, tx_byte_nxt;
    logic [7:0] bit_byte;

    assign map_now = map_addr(REQ.kind, REQ.addr);

    always_comb
    begin
        bit_byte = MEM_RDATA;
        bit_byte[bitpos_r] = |req_r.wdata;
        state_nxt = state_r;
        req_nxt = req_r;
        mem_nxt = mem_r;
        bitpos_nxt = bitpos_r;
        mem_req_nxt = mem_req_r;
        ready_nxt = 1'b0;
        rsp_valid_nxt = 1'b0;
        rsp_err_nxt = rsp_err_r;
        rsp_data_nxt = rsp_data_r;
        tx_valid_nxt = 1'b0;
        tx_byte_nxt = tx_byte_r;
        unique case (state_r)
            mbmap_pkg::MBMAP_S_IDLE:
            begin
                ready_nxt = 1'b1;
                if (REQ_VALID && ready_r)
                begin
                    ready_nxt = 1'b0;
                    req_nxt = REQ;
                    rsp_data_nxt = mbmap_pkg::RSP_ZERO;
                    if (!map_now.ok || (REQ.write && is_rd_only(REQ.kind)))
                    begin
                        rsp_err_nxt = 1'b1;
                        rsp_valid_nxt = 1'b1;
                        state_nxt = mbmap_pkg::MBMAP_S_RESP;
                    end
                    else
                    begin
                        rsp_err_nxt = 1'b0;
                        bitpos_nxt = map_now.bitpos;
                        mem_nxt.region = map_now.region;
                        mem_nxt.addr = map_now.byte_addr;
                        // a bit write first reads the byte it lives in
                        mem_nxt.we = REQ.write && !is_bit(REQ.kind);
                        mem_nxt.wdata = REQ.wdata[7:0];
                        mem_req_nxt = 1'b1;
                        state_nxt = mbmap_pkg::MBMAP_S_ACC_LO;
                    end
                end
            end
            mbmap_pkg::MBMAP_S_ACC_LO:
            begin
                if (MEM_ACK)
                begin
                    if (is_bit(req_r.kind) && req_r.write)
                    begin
                        mem_nxt.we = 1'b1;
                        mem_nxt.wdata = bit_byte;
                        state_nxt = mbmap_pkg::MBMAP_S_BIT_WR;
                    end
                    else if (is_bit(req_r.kind))
                    begin
                        mem_req_nxt = 1'b0;
                        rsp_data_nxt = {15'h0000, MEM_RDATA[bitpos_r]};
                        rsp_valid_nxt = 1'b1;
                        state_nxt = mbmap_pkg::MBMAP_S_RESP;
                    end
                    else
                    begin
                        // neighbour byte is part of the register too
                        rsp_data_nxt[7:0] = MEM_RDATA;
                        mem_nxt.addr = mem_r.addr + 17'h00001;
                        mem_nxt.wdata = req_r.wdata[15:8];
                        state_nxt = mbmap_pkg::MBMAP_S_ACC_HI;
                    end
                end
            end
            mbmap_pkg::MBMAP_S_ACC_HI:
            begin
                if (MEM_ACK)
                begin
                    mem_req_nxt = 1'b0;
                    if (req_r.write)
                    begin
                        rsp_valid_nxt = 1'b1;
                        state_nxt = mbmap_pkg::MBMAP_S_RESP;
                    end
                    else
                    begin
                        rsp_data_nxt[15:8] = MEM_RDATA;
                        tx_valid_nxt = 1'b1;
                        tx_byte_nxt = MEM_RDATA;
                        state_nxt = mbmap_pkg::MBMAP_S_TX_HI;
                    end
                end
            end
            mbmap_pkg::MBMAP_S_BIT_WR:
            begin
                if (MEM_ACK)
                begin
                    mem_req_nxt = 1'b0;
                    rsp_valid_nxt = 1'b1;
                    state_nxt = mbmap_pkg::MBMAP_S_RESP;
                end
            end
            mbmap_pkg::MBMAP_S_TX_HI:
            begin
                tx_valid_nxt = 1'b1;
                tx_byte_nxt = rsp_data_r[7:0];
                state_nxt = mbmap_pkg::MBMAP_S_TX_LO;
            end
            mbmap_pkg::MBMAP_S_TX_LO:
            begin
                rsp_valid_nxt = 1'b1;
                state_nxt = mbmap_pkg::MBMAP_S_RESP;
            end
            mbmap_pkg::MBMAP_S_RESP:
            begin
                ready_nxt = 1'b1;
                state_nxt = mbmap_pkg::MBMAP_S_IDLE;
            end
            default:
            begin
                mem_req_nxt = 1'b0;
                state_nxt = mbmap_pkg::MBMAP_S_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK_SYS)
    begin
        if (RST)
        begin
            state_r <= mbmap_pkg::MBMAP_S_IDLE;
            req_r <= '0;
            mem_r <= '0;
            bitpos_r <= 3'h0;
            mem_req_r <= 1'b0;
            ready_r <= 1'b0;
            rsp_valid_r <= 1'b0;
            rsp_err_r <= 1'b0;
            rsp_data_r <= 16'h0000;
            tx_valid_r <= 1'b0;
            tx_byte_r <= 8'h00;
        end
        else
        begin
            state_r <= state_nxt;
            req_r <= req_nxt;
            mem_r <= mem_nxt;
            bitpos_r <= bitpos_nxt;
            mem_req_r <= mem_req_nxt;
            ready_r <= ready_nxt;
            rsp_valid_r <= rsp_valid_nxt;
            rsp_err_r <= rsp_err_nxt;
            rsp_data_r <= rsp_data_nxt;
            tx_valid_r <= tx_valid_nxt;
            tx_byte_r <= tx_byte_nxt;
        end
    end

    assign REQ_READY = ready_r;
    assign RSP_VALID = rsp_valid_r;
    assign RSP_ERR = rsp_err_r;
    assign RSP_DATA = rsp_data_r;
    assign TX_VALID = tx_valid_r;
    assign TX_BYTE = tx_byte_r;
    assign MEM_REQ = mem_req_r;
    assign MEM_CMD = mem_r;

endmodule : mbmap_top
`default_nettype wire
